// ---- design/pmau_pkg.sv ----
// Summary of operation
// - A write command shifts the 16-bit data field of the command register out to the PHY.
// - A read command shifts 16 bits in from the PHY and stores them in the data field.
// - The PHY register index comes from the 5-bit index field, selecting register 0 to 31.
// - Command code 01b starts a write, 10b starts a read, and the other codes start nothing.
// - The done flag is set to 1 when a read or write finishes, and it resets to 1.
// - With the completion interrupt enable set, the end of every frame sets the done event; irq rises only while that event's enable bit is also set.
// - The read failure flag is set when a read cannot complete, and it resets to 0.
// - The configuration register holds a 5-bit PHY number that resets to the port index.
// - The destination bit sends frames to the internal PHY at 0 and to the external pins at 1.
// - The shared-routing bit sends this port's external frames to port 0's management pins.
// - With the sideband pins disabled, the external pads are isolated and command writes with destination 1 ignored.
package pmau_pkg;

    // ==========================================================
    // Register map
    localparam logic [15:0] PMAU_CMD_OFS = 16'h0020;
    localparam logic [15:0] PMAU_CFG_OFS = 16'h0e04;
    localparam logic [15:0] PMAU_IRQ_STAT_OFS = 16'h0e10;
    localparam logic [15:0] PMAU_IRQ_EN_OFS = 16'h0e14;
    localparam logic [15:0] PMAU_IRQ_CLR_OFS = 16'h0e18;

    // ==========================================================
    // Field layout
    localparam int PMAU_DATA_LSB = 0;
    localparam int PMAU_IDX_LSB = 16;
    localparam int PMAU_OP_LSB = 26;
    localparam int PMAU_DONE_BIT = 28;
    localparam int PMAU_IE_BIT = 29;
    localparam int PMAU_FAIL_BIT = 30;
    localparam int PMAU_PHY_LSB = 21;
    localparam int PMAU_COM_BIT = 30;
    localparam int PMAU_DEST_BIT = 31;
    localparam int PMAU_IRQ_DONE = 0;
    localparam int PMAU_IRQ_FAIL = 1;

    // ==========================================================
    // Reset values and codes
    localparam logic PMAU_DONE_RST = 1'b1;
    localparam logic PMAU_FAIL_RST = 1'b0;
    localparam logic [1:0] PMAU_OP_WRITE = 2'h1;
    localparam logic [1:0] PMAU_OP_READ = 2'h2;

    // ==========================================================
    // Frame layout
    localparam logic [31:0] PMAU_PREAMBLE = 32'hffffffff;
    localparam logic [1:0] PMAU_START = 2'h1;
    localparam logic [1:0] PMAU_TA_WRITE = 2'h2;
    localparam logic [1:0] PMAU_TA_READ = 2'h3;
    localparam logic [15:0] PMAU_IDLE_DATA = 16'hffff;
    localparam logic [6:0] PMAU_FRAME_BITS = 7'h40;
    localparam logic [6:0] PMAU_READ_DRIVE_BITS = 7'h2e;
    localparam logic [6:0] PMAU_TA2_POS = 7'h2f;
    localparam logic [6:0] PMAU_DATA_POS = 7'h30;

    typedef enum logic [0:0] {
        PMAU_IDLE = 1'b0,
        PMAU_SHIFT = 1'b1
    } pmau_state_t;

    typedef enum logic [1:0] {
        PMAU_RT_INT = 2'b00,
        PMAU_RT_EXT = 2'b01,
        PMAU_RT_SHARED = 2'b10
    } pmau_route_t;

endpackage : pmau_pkg

// ---- design/pmau_top.sv ----
`timescale 1ns/1ps
module pmau_top #(
    parameter logic [4:0] PORT_INDEX = 5'h00
) (
    input wire logic sys_clk, // core clock
    input wire logic reset_n, // async reset
    input wire logic [15:0] reg_addr, // register byte address
    input wire logic [31:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [31:0] reg_rdata, // read data, cycle after strobe
    output logic irq, // level interrupt
    input wire logic twowire_pins_enable, // sideband pins enable
    input wire logic mgmt_clk_in, // management link clock
    input wire logic int_mdio_i, // internal PHY data in
    output logic int_mdio_o, // internal PHY data out
    output logic int_mdio_oe, // internal PHY drive enable
    input wire logic ext_mdio_i, // own external pin in
    output logic ext_mdio_o, // own external pin out
    output logic ext_mdio_oe, // own external pin enable
    input wire logic shared_mdio_i, // port 0 pin in
    output logic shared_mdio_o, // port 0 pin out
    output logic shared_mdio_oe // port 0 pin enable
);
    import pmau_pkg::*;

    // ==========================================================
    // State
    typedef struct packed {
        pmau_state_t state;
        pmau_route_t route;
        logic mdc_s1;
        logic mdc_s2;
        logic mdc_d;
        logic mdio_s1;
        logic mdio_s2;
        logic [15:0] data;
        logic [4:0] idx;
        logic [1:0] op;
        logic done;
        logic ie;
        logic fail;
        logic [4:0] phy;
        logic com;
        logic dest;
        logic [63:0] frame;
        logic [6:0] cnt;
        logic [15:0] rx;
        logic ta_bad;
        logic dout;
        logic [2:0] oe3;
        logic [1:0] irq_stat;
        logic [1:0] irq_en;
        logic [31:0] rdata;
    } pmau_regs_t;

    localparam pmau_regs_t PMAU_RESET = '{
        state: PMAU_IDLE, route: PMAU_RT_INT,
        mdc_s1: 1'b0, mdc_s2: 1'b0, mdc_d: 1'b0,
        mdio_s1: 1'b1, mdio_s2: 1'b1,
        data: 16'h0000, idx: 5'h00, op: 2'h0,
        done: PMAU_DONE_RST, ie: 1'b0, fail: PMAU_FAIL_RST,
        phy: PORT_INDEX, com: 1'b0, dest: 1'b0,
        frame: 64'h0000000000000000, cnt: 7'h00, rx: 16'h0000,
        ta_bad: 1'b0, dout: 1'b1, oe3: 3'h0,
        irq_stat: 2'h0, irq_en: 2'h0, rdata: 32'h00000000
    };

    pmau_regs_t r_reg;
    pmau_regs_t r_next;
    logic rise;
    logic fall;
    logic fin;
    logic start;
    logic [6:0] pos;
    logic [2:0] route_oh;
    logic [15:0] rd_word;
    pmau_route_t new_route;

    // ==========================================================
    // Next state
    always_comb begin
        r_next = r_reg;
        fin = 1'b0;
        start = 1'b0;
        rd_word = {r_reg.rx[14:0], r_reg.mdio_s2};
        // The link clock is sampled, so each of its edges is seen two core cycles late.
        r_next.mdc_s1 = mgmt_clk_in;
        r_next.mdc_s2 = r_reg.mdc_s1;
        r_next.mdc_d = r_reg.mdc_s2;
        rise = r_reg.mdc_s2 & ~r_reg.mdc_d;
        fall = ~r_reg.mdc_s2 & r_reg.mdc_d;
        pos = r_reg.cnt - 7'h01;
        unique case (r_reg.route)
            PMAU_RT_INT: begin
                r_next.mdio_s1 = int_mdio_i;
                route_oh = 3'h1;
            end
            PMAU_RT_EXT: begin
                r_next.mdio_s1 = ext_mdio_i;
                route_oh = 3'h2;
            end
            PMAU_RT_SHARED: begin
                r_next.mdio_s1 = shared_mdio_i;
                route_oh = 3'h4;
            end
            default: begin
                r_next.mdio_s1 = 1'b1;
                route_oh = 3'h0;
            end
        endcase
        r_next.mdio_s2 = r_reg.mdio_s1;
        // Only the command register path exists here, so the destination and shared-routing bits alone decide.
        if (r_reg.dest) begin
            new_route = r_reg.com ? PMAU_RT_SHARED : PMAU_RT_EXT;
        end else begin
            new_route = PMAU_RT_INT;
        end

        // Frame engine: bits change after a falling edge and are sampled after a rising one.
        if (r_reg.state == PMAU_SHIFT) begin
            if (fall && r_reg.cnt != PMAU_FRAME_BITS) begin
                r_next.dout = r_reg.frame[63];
                r_next.frame = {r_reg.frame[62:0], 1'b1};
                r_next.cnt = r_reg.cnt + 7'h01;
                if (r_reg.op == PMAU_OP_WRITE || r_reg.cnt < PMAU_READ_DRIVE_BITS) begin
                    r_next.oe3 = route_oh;
                end else begin
                    r_next.oe3 = 3'h0;
                end
            end
            if (rise && r_reg.cnt != 7'h00) begin
                // A PHY that answers pulls the second turnaround bit low.
                if (r_reg.op == PMAU_OP_READ && pos == PMAU_TA2_POS && r_reg.mdio_s2) begin
                    r_next.ta_bad = 1'b1;
                end
                if (r_reg.op == PMAU_OP_READ && pos >= PMAU_DATA_POS) begin
                    r_next.rx = rd_word;
                end
                if (r_reg.cnt == PMAU_FRAME_BITS) begin
                    fin = 1'b1;
                    r_next.state = PMAU_IDLE;
                    r_next.oe3 = 3'h0;
                    r_next.done = 1'b1;
                    if (r_reg.op == PMAU_OP_READ) begin
                        r_next.data = rd_word;
                        r_next.fail = r_reg.ta_bad;
                    end
                end
            end
        end

        // Command writes are taken only while idle, so a finishing frame never races them.
        if (reg_wr && reg_addr == PMAU_CMD_OFS && r_reg.state == PMAU_IDLE) begin
            if (twowire_pins_enable || r_reg.dest == 1'b0) begin
                r_next.data = reg_wdata[PMAU_DATA_LSB +: 16];
                r_next.idx = reg_wdata[PMAU_IDX_LSB +: 5];
                r_next.op = reg_wdata[PMAU_OP_LSB +: 2];
                r_next.ie = reg_wdata[PMAU_IE_BIT];
                r_next.done = reg_wdata[PMAU_DONE_BIT];
                r_next.fail = reg_wdata[PMAU_FAIL_BIT];
                start = (reg_wdata[PMAU_OP_LSB +: 2] == PMAU_OP_WRITE)
                    || (reg_wdata[PMAU_OP_LSB +: 2] == PMAU_OP_READ);
            end
        end
        if (start) begin
            r_next.state = PMAU_SHIFT;
            r_next.cnt = 7'h00;
            r_next.ta_bad = 1'b0;
            r_next.route = new_route;
            if (reg_wdata[PMAU_OP_LSB +: 2] == PMAU_OP_WRITE) begin
                r_next.frame = {PMAU_PREAMBLE, PMAU_START, PMAU_OP_WRITE, r_reg.phy,
                    reg_wdata[PMAU_IDX_LSB +: 5], PMAU_TA_WRITE,
                    reg_wdata[PMAU_DATA_LSB +: 16]};
            end else begin
                r_next.frame = {PMAU_PREAMBLE, PMAU_START, PMAU_OP_READ, r_reg.phy,
                    reg_wdata[PMAU_IDX_LSB +: 5], PMAU_TA_READ, PMAU_IDLE_DATA};
            end
        end
        if (reg_wr && reg_addr == PMAU_CFG_OFS) begin
            r_next.phy = reg_wdata[PMAU_PHY_LSB +: 5];
            r_next.com = reg_wdata[PMAU_COM_BIT];
            r_next.dest = reg_wdata[PMAU_DEST_BIT];
        end

        // Sticky events: a set in the same cycle as a clear wins.
        if (reg_wr && reg_addr == PMAU_IRQ_CLR_OFS) begin
            r_next.irq_stat = r_reg.irq_stat & ~reg_wdata[1:0];
        end
        if (fin && r_reg.ie) begin
            r_next.irq_stat[PMAU_IRQ_DONE] = 1'b1;
        end
        if (fin && r_reg.op == PMAU_OP_READ && r_reg.ta_bad) begin
            r_next.irq_stat[PMAU_IRQ_FAIL] = 1'b1;
        end
        if (reg_wr && reg_addr == PMAU_IRQ_EN_OFS) begin
            r_next.irq_en = reg_wdata[1:0];
        end

        // Read data stand for exactly one cycle; unmapped addresses read zero.
        r_next.rdata = 32'h00000000;
        if (reg_rd) begin
            if (reg_addr == PMAU_CMD_OFS) begin
                r_next.rdata = {1'b0, r_reg.fail, r_reg.ie, r_reg.done, r_reg.op,
                    5'h00, r_reg.idx, r_reg.data};
            end else if (reg_addr == PMAU_CFG_OFS) begin
                r_next.rdata = {r_reg.dest, r_reg.com, 4'h0, r_reg.phy, 21'h000000};
            end else if (reg_addr == PMAU_IRQ_STAT_OFS) begin
                r_next.rdata = {30'h00000000, r_reg.irq_stat};
            end else if (reg_addr == PMAU_IRQ_EN_OFS) begin
                r_next.rdata = {30'h00000000, r_reg.irq_en};
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            r_reg <= PMAU_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    // ==========================================================
    // Outputs
    assign reg_rdata = r_reg.rdata;
    assign irq = |(r_reg.irq_stat & r_reg.irq_en);
    assign int_mdio_o = r_reg.dout;
    assign ext_mdio_o = r_reg.dout;
    assign shared_mdio_o = r_reg.dout;
    assign int_mdio_oe = r_reg.oe3[0];
    // Pads stay isolated whenever the sideband pins are off, even mid-frame.
    assign ext_mdio_oe = r_reg.oe3[1] & twowire_pins_enable;
    assign shared_mdio_oe = r_reg.oe3[2] & twowire_pins_enable;

    // ==========================================================
    // Checks
    property p_done_set;
        @(posedge sys_clk) disable iff (!reset_n)
        fin |=> r_reg.done && r_reg.state == PMAU_IDLE;
    endproperty
    a_done_set: assert property (p_done_set) else $error("done not set at frame end");

    property p_read_store;
        @(posedge sys_clk) disable iff (!reset_n)
        (fin && r_reg.op == PMAU_OP_READ) |=> r_reg.data == $past(rd_word);
    endproperty
    a_read_store: assert property (p_read_store) else $error("read data not stored");

    property p_write_drive;
        @(posedge sys_clk) disable iff (!reset_n)
        (r_reg.state == PMAU_SHIFT && r_reg.op == PMAU_OP_WRITE && r_reg.cnt != 7'h00)
            |-> r_reg.oe3 != 3'h0;
    endproperty
    a_write_drive: assert property (p_write_drive) else $error("write frame released");

    property p_read_release;
        @(posedge sys_clk) disable iff (!reset_n)
        (r_reg.state == PMAU_SHIFT && r_reg.op == PMAU_OP_READ && r_reg.cnt > PMAU_READ_DRIVE_BITS)
            |-> r_reg.oe3 == 3'h0;
    endproperty
    a_read_release: assert property (p_read_release) else $error("read not released");

    property p_irq_done;
        @(posedge sys_clk) disable iff (!reset_n)
        (fin && r_reg.ie) |=> r_reg.irq_stat[PMAU_IRQ_DONE] ##0 (irq == r_reg.irq_en[PMAU_IRQ_DONE])
            || r_reg.irq_stat[PMAU_IRQ_FAIL];
    endproperty
    a_irq_done: assert property (p_irq_done) else $error("completion interrupt lost");

    property p_fail_flag;
        @(posedge sys_clk) disable iff (!reset_n)
        (fin && r_reg.op == PMAU_OP_READ) |=> r_reg.fail == $past(r_reg.ta_bad);
    endproperty
    a_fail_flag: assert property (p_fail_flag) else $error("failure flag wrong");

    property p_isolate;
        @(posedge sys_clk) disable iff (!reset_n)
        !twowire_pins_enable |-> !ext_mdio_oe && !shared_mdio_oe;
    endproperty
    a_isolate: assert property (p_isolate) else $error("pads driven while isolated");

    property p_bad_code;
        @(posedge sys_clk) disable iff (!reset_n)
        (reg_wr && reg_addr == PMAU_CMD_OFS && r_reg.state == PMAU_IDLE
            && reg_wdata[PMAU_OP_LSB +: 2] != PMAU_OP_WRITE
            && reg_wdata[PMAU_OP_LSB +: 2] != PMAU_OP_READ) |=> r_reg.state == PMAU_IDLE;
    endproperty
    a_bad_code: assert property (p_bad_code) else $error("reserved code started frame");

    property p_route_shared;
        @(posedge sys_clk) disable iff (!reset_n)
        (r_reg.route == PMAU_RT_SHARED) |-> r_reg.oe3[1:0] == 2'h0;
    endproperty
    a_route_shared: assert property (p_route_shared) else $error("shared route leaks");

    property p_frame_len;
        @(posedge sys_clk) disable iff (!reset_n)
        r_reg.cnt <= PMAU_FRAME_BITS;
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame too long");

    // The route is latched at start, so a later config write cannot move a running frame.
    property p_route_int;
        @(posedge sys_clk) disable iff (!reset_n)
        (start && !r_reg.dest) |=> r_reg.route == PMAU_RT_INT;
    endproperty
    a_route_int: assert property (p_route_int) else $error("bad internal route");

    property p_route_ext;
        @(posedge sys_clk) disable iff (!reset_n)
        (start && r_reg.dest && !r_reg.com) |=> r_reg.route == PMAU_RT_EXT;
    endproperty
    a_route_ext: assert property (p_route_ext) else $error("bad external route");

    property p_route_com;
        @(posedge sys_clk) disable iff (!reset_n)
        (start && r_reg.dest && r_reg.com) |=> r_reg.route == PMAU_RT_SHARED;
    endproperty
    a_route_com: assert property (p_route_com) else $error("bad shared route");

    property p_index_take;
        @(posedge sys_clk) disable iff (!reset_n)
        start |=> r_reg.idx == $past(reg_wdata[PMAU_IDX_LSB +: 5]);
    endproperty
    a_index_take: assert property (p_index_take) else $error("index not taken");

    property p_frame_start;
        @(posedge sys_clk) disable iff (!reset_n)
        start |=> r_reg.state == PMAU_SHIFT && r_reg.cnt == 7'h00;
    endproperty
    a_frame_start: assert property (p_frame_start) else $error("frame not started");

    // Only a read can fail; a write frame must leave the flag as software wrote it.
    property p_write_no_fail;
        @(posedge sys_clk) disable iff (!reset_n)
        (fin && r_reg.op == PMAU_OP_WRITE) |=> r_reg.fail == $past(r_reg.fail);
    endproperty
    a_write_no_fail: assert property (p_write_no_fail) else $error("write set failure");

    property p_rdata_idle;
        @(posedge sys_clk) disable iff (!reset_n)
        !reg_rd |=> reg_rdata == 32'h00000000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("stale read data");

endmodule : pmau_top

// ---- testbench/pmau_phy_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// Management PHY model: a register file behind one management line.
module pmau_phy_model (
    input wire logic mdc, // link clock
    input wire logic dut_o, // device frame bit
    input wire logic dut_oe, // device drive enable
    input wire logic fail_mode, // leave the turnaround undriven
    output logic wire_q, // resolved line level
    output logic [63:0] frame, // last frame, first bit at the top
    output logic [7:0] frames // finished frame count
);
    logic [15:0] regs [32];
    logic [63:0] sr;
    logic [16:0] sh;
    logic [6:0] cnt = 7'h00;
    logic armed = 1'b1;
    logic rd = 1'b0;
    logic drv = 1'b1;
    // A released line floats to its pull-up, never to a stale value.
    assign wire_q = dut_oe ? dut_o : drv;
    initial frames = 8'h00;
    always @(posedge mdc) begin
        if (cnt != 7'h00 || (dut_oe && armed)) begin
            sr = {sr[62:0], wire_q};
            cnt = cnt + 7'h01;
            armed = 1'b0;
        end else if (!dut_oe) begin
            armed = 1'b1;
        end
        if (cnt == 7'h40) begin
            cnt = 7'h00;
            frame = sr;
            frames = frames + 8'h01;
            if (sr[29:28] == 2'h1) begin
                regs[sr[22:18]] = sr[15:0];
            end
        end
    end
    // The answer changes on the falling edge so the device samples it settled.
    always @(negedge mdc) begin
        if (cnt == 7'h2e) begin
            rd = (sr[11:10] == 2'h2) && !fail_mode;
            sh = {1'b0, regs[sr[4:0]]};
        end
        // First turnaround bit floats, the second is pulled low, then data MSB first.
        if (rd && cnt >= 7'h2f && cnt <= 7'h3f) begin
            drv = sh[16];
            sh = {sh[15:0], 1'b0};
        end else begin
            drv = 1'b1;
        end
    end
endmodule : pmau_phy_model

// ---- testbench/tb_phy_mgmt_access_unit.sv ----
`timescale 1ns/1ps
module tb_phy_mgmt_access_unit;
    import pmau_pkg::*;
    typedef struct packed {
        logic [31:0] cfg;
        logic [31:0] cmd;
        logic [15:0] data;
        logic [1:0] route;
    } pmau_row_t;
    localparam logic [4:0] PORT_NUM = 5'h03;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic mdc = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [31:0] reg_wdata = 32'h00000000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic pins_en = 1'b1;
    logic [2:0] fail = 3'h0;
    logic [31:0] reg_rdata;
    logic irq;
    logic [31:0] rd_val;
    logic [23:0] old;
    wire [2:0] mo, moe, mi;
    wire [63:0] frm [3];
    wire [7:0] nfr [3];
    wire [23:0] counts = {nfr[2], nfr[1], nfr[0]};
    int miscompares = 0;
    int check_count = 0;
    pmau_row_t rows [6] = '{
        '{32'h00a00000, 32'h2403a5c3, 16'ha5c3, 2'd0},
        '{32'h00a00000, 32'h08030000, 16'ha5c3, 2'd0},
        '{32'h83e00000, 32'h241f0001, 16'h0001, 2'd1},
        '{32'h83e00000, 32'h081f0000, 16'h0001, 2'd1},
        '{32'hc0000000, 32'h04008000, 16'h8000, 2'd2},
        '{32'hc0000000, 32'h28000000, 16'h8000, 2'd2}};
    always #50 sys_clk = ~sys_clk;
    always #400 mdc = ~mdc;
    pmau_top #(.PORT_INDEX(PORT_NUM)) dut (.sys_clk(sys_clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq), .twowire_pins_enable(pins_en), .mgmt_clk_in(mdc),
        .int_mdio_i(mi[0]), .int_mdio_o(mo[0]), .int_mdio_oe(moe[0]),
        .ext_mdio_i(mi[1]), .ext_mdio_o(mo[1]), .ext_mdio_oe(moe[1]),
        .shared_mdio_i(mi[2]), .shared_mdio_o(mo[2]), .shared_mdio_oe(moe[2]));
    for (genvar i = 0; i < 3; i++) begin : g_phy
        pmau_phy_model phy (.mdc(mdc), .dut_o(mo[i]), .dut_oe(moe[i]), .fail_mode(fail[i]),
            .wire_q(mi[i]), .frame(frm[i]), .frames(nfr[i]));
    end
    // ==========================================================
    // Bus and report tasks
    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check
    task automatic final_report();
        $display("checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
        @(posedge sys_clk);
        #1 check("read data after its cycle", 64'h0, 64'(reg_rdata));
    endtask : rd
    // Polls far longer than one 64-bit frame lasts before giving up.
    task automatic wait_done();
        for (int i = 0; i < 400; i++) begin
            rd(PMAU_CMD_OFS);
            if (rd_val[PMAU_DONE_BIT] === 1'b1) return;
        end
        check("done flag wait", 64'h1, 64'h0);
        final_report();
    endtask : wait_done
    initial begin
        #5000000;
        check("run time limit", 64'h1, 64'h0);
        final_report();
    end
    // ==========================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        wr(PMAU_IRQ_EN_OFS, 32'h3);
        rd(PMAU_IRQ_EN_OFS);
        check("irq enable", 64'h3, 64'(rd_val));
        foreach (rows[i]) begin
            old = counts;
            wr(PMAU_CFG_OFS, rows[i].cfg);
            wr(PMAU_CMD_OFS, rows[i].cmd);
            wait_done();
            check("command word", 64'({2'b00, rows[i].cmd[29], 1'b1, rows[i].cmd[27:16],
                rows[i].data}), 64'(rd_val));
            check("frame", {32'hffffffff, 2'b01, rows[i].cmd[27:26], rows[i].cfg[25:21],
                rows[i].cmd[20:16], 2'b10, rows[i].data}, frm[rows[i].route]);
            check("frame counts", 64'(old + (24'h1 << (8 * rows[i].route))),
                64'(counts));
            check("irq", 64'(rows[i].cmd[29]), 64'(irq));
            wr(PMAU_IRQ_CLR_OFS, 32'h3);
        end
        fail <= 3'h1;
        wr(PMAU_CFG_OFS, 32'h0);
        wr(PMAU_CMD_OFS, 32'h08030000);
        wait_done();
        check("read failure flag", 64'h1, 64'(rd_val[PMAU_FAIL_BIT]));
        rd(PMAU_IRQ_STAT_OFS);
        check("irq status", 64'h2, 64'(rd_val));
        check("irq line", 64'h1, 64'(irq));
        wr(PMAU_IRQ_EN_OFS, 32'h1);
        #1 check("masked irq", 64'h0, 64'(irq));
        wr(PMAU_IRQ_CLR_OFS, 32'h2);
        rd(PMAU_IRQ_STAT_OFS);
        check("cleared status", 64'h0, 64'(rd_val));
        fail <= 3'h0;
        wr(PMAU_IRQ_EN_OFS, 32'h3);
        // A second command while the frame runs must be dropped whole.
        wr(PMAU_CMD_OFS, 32'h04041234);
        wr(PMAU_CMD_OFS, 32'h04045678);
        wait_done();
        check("busy write", 64'h1234, 64'(rd_val[15:0]));
        check("busy frame", 64'h1234, 64'(frm[0][15:0]));
        old = counts;
        wr(PMAU_CMD_OFS, 32'h10020000);
        wr(PMAU_CMD_OFS, 32'h1c02000f);
        repeat (700) @(posedge sys_clk);
        rd(PMAU_CMD_OFS);
        check("reserved code word", 64'h1c02000f, 64'(rd_val));
        check("reserved code frames", 64'(old), 64'(counts));
        pins_en <= 1'b0;
        wr(PMAU_CFG_OFS, 32'h80000000);
        wr(PMAU_CMD_OFS, 32'h04011111);
        repeat (700) @(posedge sys_clk);
        rd(PMAU_CMD_OFS);
        check("isolated command", 64'h1c02000f, 64'(rd_val));
        check("isolated frames", 64'(old), 64'(counts));
        pins_en <= 1'b1;
        wr(PMAU_CFG_OFS, 32'h0);
        wr(PMAU_CMD_OFS, 32'h04051111);
        repeat (200) @(posedge sys_clk);
        reset_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        check("drive enables in reset", 64'h0, 64'(moe));
        reset_n <= 1'b1;
        rd(PMAU_CMD_OFS);
        check("command reset", 64'h10000000, 64'(rd_val));
        rd(PMAU_CFG_OFS);
        check("config reset", 64'({6'h00, PORT_NUM, 21'h0}), 64'(rd_val));
        rd(16'h0100);
        check("unmapped read", 64'h0, 64'(rd_val));
        rd(PMAU_IRQ_CLR_OFS);
        check("clear register read", 64'h0, 64'(rd_val));
        final_report();
    end
endmodule : tb_phy_mgmt_access_unit
